// File: hw/nvm_ctrl.sv
// Data EEPROM access controller: registers, read sequencing and program timer
// Summary of operation
// - Address register holds seven bits; its top bit reads zero.
// - Control register at 40H of sector one; address and data in sector zero.
// - Time select bit picks 3.2/2.2 ms or 3.7/3.0 ms erase/write times.
// - Erase needs erase enable; hardware clears enable after the erase.
// - Erase start begins an erase, self-clears, ignored without erase enable.
// - Mode bit chooses byte or 16-byte page operation.
// - Writes need write enable; hardware clears enable after the write.
// - Write start begins a write, self-clears, ignored without write enable.
// - Reads are inhibited while read enable is zero.
// - Read start begins a read, self-clears, ignored without read enable.
// - Byte read leaves the byte in the data register until next operation.
// - Page read loads data, then increments address and clears read start in the same cycle.
// - Each new page read start fetches the next byte without reloading.
// - In page mode only the low four address bits increment.
// - The incremented offset stops at 0FH and never wraps.
// - A byte write erases the target byte first.
// - Erase and write are timed internally; completion clears the start bit.
`timescale 1ns/100ps
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int unsigned ER0_CYC = `NVM_T_ER0_US * `NVM_CLK_MHZ,  // Erase time, normal
  parameter int unsigned WR0_CYC = `NVM_T_WR0_US * `NVM_CLK_MHZ,  // Write time, normal
  parameter int unsigned ER1_CYC = `NVM_T_ER1_US * `NVM_CLK_MHZ,  // Erase time, long
  parameter int unsigned WR1_CYC = `NVM_T_WR1_US * `NVM_CLK_MHZ   // Write time, long
) (
  input  wire logic         clk_i,         // System clock
  input  wire logic         rst_n_i,       // Async reset, active low
  input  wire nvm_mem_req_t mem_req_i,     // CPU data memory access
  output logic [7:0]        mem_rdata_o,   // Read data for last cycle's address
  output logic [6:0]        arr_addr_o,    // Array address
  output logic [7:0]        arr_wdata_o,   // Array write data
  output logic              arr_rd_o,      // Array read strobe
  output logic              arr_erase_o,   // Array erase strobe
  output logic              arr_write_o,   // Array program strobe
  input  wire logic [7:0]   arr_rdata_i,   // Array read data, cycle after strobe
  output logic              busy_o         // Erase or write in progress
);

  nvm_state_s_t q;
  nvm_state_s_t d;
  logic         wr_addr;
  logic         wr_data;
  logic         wr_ctrl;
  logic [7:0]   cw;

  // Sized copies of the times so the counter loads without truncation surprises
  localparam logic [`NVM_CNT_W-1:0] ER0_L = ER0_CYC[`NVM_CNT_W-1:0] - 1'b1;
  localparam logic [`NVM_CNT_W-1:0] WR0_L = WR0_CYC[`NVM_CNT_W-1:0] - 1'b1;
  localparam logic [`NVM_CNT_W-1:0] ER1_L = ER1_CYC[`NVM_CNT_W-1:0] - 1'b1;
  localparam logic [`NVM_CNT_W-1:0] WR1_L = WR1_CYC[`NVM_CNT_W-1:0] - 1'b1;

  // Address decode of the CPU access
  assign wr_addr = mem_req_i.wr && (mem_req_i.addr == `NVM_ADDR_OFS);
  assign wr_data = mem_req_i.wr && (mem_req_i.addr == `NVM_DATA_OFS);
  assign wr_ctrl = mem_req_i.wr && (mem_req_i.addr == `NVM_CTRL_OFS);
  assign cw      = mem_req_i.wdata;

  // Next-state logic
  always_comb begin
    d        = q;
    d.arr_rd = 1'b0;
    d.arr_er = 1'b0;
    d.arr_wr = 1'b0;
    d.tdone  = 1'b0;
    // Completion pulse crosses two flops before anything software sees moves
    d.sync1  = q.tdone;
    d.sync2  = q.sync1;

    // Software writes
    if (wr_addr) begin
      d.addr = cw[6:0];
    end
    if (wr_data) begin
      d.data = cw;
    end
    if (wr_ctrl) begin
      d.ctrl = cw;
      // A start bit only sticks when its enable was already set
      d.ctrl[`NVM_B_ER_GO] = cw[`NVM_B_ER_GO] & q.ctrl[`NVM_B_ER_EN];
      d.ctrl[`NVM_B_WR_GO] = cw[`NVM_B_WR_GO] & q.ctrl[`NVM_B_WR_EN];
      d.ctrl[`NVM_B_RD_GO] = cw[`NVM_B_RD_GO] & q.ctrl[`NVM_B_RD_EN];
    end

    // Sequencer; software is trusted to stay off the registers while busy
    unique case (q.st)
      ST_IDLE: begin
        // Erase ranks first should software ever set two starts
        if (q.ctrl[`NVM_B_ER_GO] && q.ctrl[`NVM_B_ER_EN]) begin
          d.st     = ST_ERASE;
          d.op_wr  = 1'b0;
          d.arr_er = 1'b1;
          d.cnt    = q.ctrl[`NVM_B_TSEL] ? ER1_L : ER0_L;
        end else if (q.ctrl[`NVM_B_WR_GO] && q.ctrl[`NVM_B_WR_EN]) begin
          d.op_wr = 1'b1;
          if (!q.ctrl[`NVM_B_PAGE]) begin
            // Byte write is preceded by an erase of the same byte
            d.st     = ST_WR_ERASE;
            d.arr_er = 1'b1;
            d.cnt    = q.ctrl[`NVM_B_TSEL] ? ER1_L : ER0_L;
          end else begin
            d.st     = ST_WRITE;
            d.arr_wr = 1'b1;
            d.cnt    = q.ctrl[`NVM_B_TSEL] ? WR1_L : WR0_L;
          end
        end else if (q.ctrl[`NVM_B_RD_GO] && q.ctrl[`NVM_B_RD_EN]) begin
          d.st     = ST_RD_REQ;
          d.arr_rd = 1'b1;
        end
      end
      ST_RD_REQ: begin
        d.st = ST_RD_CAP;
      end
      ST_RD_CAP: begin
        // Array answers the cycle after the strobe
        d.data = arr_rdata_i;
        d.st   = ST_RD_DONE;
      end
      ST_RD_DONE: begin
        // Page offset steps after the load, stopping at the page end
        if (q.ctrl[`NVM_B_PAGE] && (q.addr[3:0] != `NVM_PAGE_LAST)) begin
          d.addr = {q.addr[6:4], q.addr[3:0] + 4'h1};
        end
        d.ctrl[`NVM_B_RD_GO] = 1'b0;
        d.st = ST_IDLE;
      end
      ST_ERASE, ST_WRITE: begin
        if (q.cnt == '0) begin
          d.tdone = 1'b1;
          d.st    = ST_WAIT;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      ST_WR_ERASE: begin
        if (q.cnt == '0) begin
          d.st     = ST_WRITE;
          d.arr_wr = 1'b1;
          d.cnt    = q.ctrl[`NVM_B_TSEL] ? WR1_L : WR0_L;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      ST_WAIT: begin
        if (q.sync2) begin
          if (q.op_wr) begin
            d.ctrl[`NVM_B_WR_GO] = 1'b0;
            d.ctrl[`NVM_B_WR_EN] = 1'b0;
          end else begin
            d.ctrl[`NVM_B_ER_GO] = 1'b0;
            d.ctrl[`NVM_B_ER_EN] = 1'b0;
          end
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Busy follows the next state so the pin comes off a flop, never a stale write flag
    d.busy = (d.st == ST_ERASE) || (d.st == ST_WR_ERASE) || (d.st == ST_WRITE) || (d.st == ST_WAIT);

    // Registered read port; unmapped locations read zero
    if (mem_req_i.addr == `NVM_ADDR_OFS) begin
      d.rdata = {1'b0, q.addr};
    end else if (mem_req_i.addr == `NVM_DATA_OFS) begin
      d.rdata = q.data;
    end else if (mem_req_i.addr == `NVM_CTRL_OFS) begin
      d.rdata = q.ctrl;
    end else begin
      d.rdata = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.addr  <= `NVM_ADDR_RST;
      q.data  <= `NVM_DATA_RST;
      q.ctrl  <= `NVM_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign mem_rdata_o = q.rdata;
  assign arr_addr_o  = q.addr;
  assign arr_wdata_o = q.data;
  assign arr_rd_o    = q.arr_rd;
  assign arr_erase_o = q.arr_er;
  assign arr_write_o = q.arr_wr;
  assign busy_o      = q.busy;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_strobe;
    arr_rd_o ##1 1'b1;
  endsequence

  property p_addr_top_zero;
    $past(mem_req_i.addr) == `NVM_ADDR_OFS |-> mem_rdata_o[7] == 1'b0;
  endproperty
  a_addr_top_zero: assert property (p_addr_top_zero) else $error("address top bit not zero");

  property p_er_go_needs_en;
    (wr_ctrl && cw[`NVM_B_ER_GO] && !q.ctrl[`NVM_B_ER_EN]) |=> !q.ctrl[`NVM_B_ER_GO];
  endproperty
  a_er_go_needs_en: assert property (p_er_go_needs_en) else $error("erase start taken without enable");

  property p_rd_go_needs_en;
    (wr_ctrl && cw[`NVM_B_RD_GO] && !q.ctrl[`NVM_B_RD_EN]) |=> !q.ctrl[`NVM_B_RD_GO];
  endproperty
  a_rd_go_needs_en: assert property (p_rd_go_needs_en) else $error("read start taken without enable");

  property p_rd_capture;
    s_rd_strobe |=> (q.data == $past(arr_rdata_i));
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read data not captured");

  property p_rd_clear;
    arr_rd_o |-> ##3 !q.ctrl[`NVM_B_RD_GO];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read start not cleared");

  property p_page_inc;
    (q.st == ST_RD_DONE && q.ctrl[`NVM_B_PAGE] && q.addr[3:0] != `NVM_PAGE_LAST)
      |=> (arr_addr_o == {$past(q.addr[6:4]), $past(q.addr[3:0]) + 4'h1});
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page offset did not step");

  property p_page_sat;
    (q.st == ST_RD_DONE && q.addr[3:0] == `NVM_PAGE_LAST) |=> arr_addr_o == $past(q.addr);
  endproperty
  a_page_sat: assert property (p_page_sat) else $error("page offset wrapped");

  property p_byte_wr_erase_first;
    arr_write_o && !q.ctrl[`NVM_B_PAGE] |-> $past(q.st) == ST_WR_ERASE;
  endproperty
  a_byte_wr_erase_first: assert property (p_byte_wr_erase_first) else $error("byte write not erased first");

  property p_done_sync;
    q.tdone |-> (q.st == ST_WAIT) [*3] ##1 (q.st == ST_IDLE);
  endproperty
  a_done_sync: assert property (p_done_sync) else $error("completion not synchronised");

  property p_erase_time;
    (q.st == ST_ERASE && q.cnt != '0) |=> q.st == ST_ERASE;
  endproperty
  a_erase_time: assert property (p_erase_time) else $error("erase ended early");

  property p_wr_go_needs_en;
    (wr_ctrl && cw[`NVM_B_WR_GO] && !q.ctrl[`NVM_B_WR_EN]) |=> !q.ctrl[`NVM_B_WR_GO];
  endproperty
  a_wr_go_needs_en: assert property (p_wr_go_needs_en) else $error("write start taken without enable");

  property p_wr_done_clear;
    (q.st == ST_WAIT && q.sync2 && q.op_wr) |=> !q.ctrl[`NVM_B_WR_GO] && !q.ctrl[`NVM_B_WR_EN];
  endproperty
  a_wr_done_clear: assert property (p_wr_done_clear) else $error("write bits not cleared");

  property p_er_done_clear;
    (q.st == ST_WAIT && q.sync2 && !q.op_wr) |=> !q.ctrl[`NVM_B_ER_GO] && !q.ctrl[`NVM_B_ER_EN];
  endproperty
  a_er_done_clear: assert property (p_er_done_clear) else $error("erase bits not cleared");

  property p_rd_needs_en;
    arr_rd_o |-> $past(q.ctrl[`NVM_B_RD_EN]);
  endproperty
  a_rd_needs_en: assert property (p_rd_needs_en) else $error("read without read enable");

  property p_page_wr_direct;
    (arr_write_o && $past(q.ctrl[`NVM_B_PAGE])) |-> $past(q.st) == ST_IDLE;
  endproperty
  a_page_wr_direct: assert property (p_page_wr_direct) else $error("page write not direct");

  property p_prog_busy;
    (arr_erase_o || arr_write_o) |-> busy_o;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy low while programming");

  property p_er_load;
    arr_erase_o |-> q.cnt == ($past(q.ctrl[`NVM_B_TSEL]) ? ER1_L : ER0_L);
  endproperty
  a_er_load: assert property (p_er_load) else $error("erase time not selected");

  property p_write_time;
    (q.st == ST_WRITE && q.cnt != '0) |=> q.st == ST_WRITE;
  endproperty
  a_write_time: assert property (p_write_time) else $error("write ended early");

endmodule

// File: hw/nvm_defines.svh
// Constants for the data EEPROM access controller
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH
// Data memory map, sector number in bit 8
`define NVM_ADDR_OFS     9'h046
`define NVM_DATA_OFS     9'h047
`define NVM_CTRL_OFS     9'h140
// Control register field positions
`define NVM_B_TSEL       3'd7
`define NVM_B_ER_EN      3'd6
`define NVM_B_ER_GO      3'd5
`define NVM_B_PAGE       3'd4
`define NVM_B_WR_EN      3'd3
`define NVM_B_WR_GO      3'd2
`define NVM_B_RD_EN      3'd1
`define NVM_B_RD_GO      3'd0
// Reset values
`define NVM_ADDR_RST     7'h00
`define NVM_DATA_RST     8'h00
`define NVM_CTRL_RST     8'h00
// Page geometry: low nibble is the offset, it stops at the page end
`define NVM_PAGE_LAST    4'hf
// Program times in microseconds and clock rate in MHz
`define NVM_T_ER0_US     3200
`define NVM_T_WR0_US     2200
`define NVM_T_ER1_US     3700
`define NVM_T_WR1_US     3000
`define NVM_CLK_MHZ      100
`define NVM_CNT_W        20
`endif

// File: hw/nvm_pkg.sv
// Types for the data EEPROM access controller
`include "nvm_defines.svh"
package nvm_pkg;
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_RD_REQ   = 8'h02,
    ST_RD_CAP   = 8'h04,
    ST_RD_DONE  = 8'h08,
    ST_ERASE    = 8'h10,
    ST_WR_ERASE = 8'h20,
    ST_WRITE    = 8'h40,
    ST_WAIT     = 8'h80
  } nvm_state_t;

  // Whole controller state
  typedef struct packed {
    nvm_state_t                st;
    logic [6:0]                addr;
    logic [7:0]                data;
    logic [7:0]                ctrl;
    logic [`NVM_CNT_W-1:0]     cnt;
    logic                      op_wr;
    logic                      tdone;
    logic                      sync1;
    logic                      sync2;
    logic [7:0]                rdata;
    logic                      arr_rd;
    logic                      arr_er;
    logic                      arr_wr;
    logic                      busy;
  } nvm_state_s_t;

  // CPU data memory access
  typedef struct packed {
    logic [8:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } nvm_mem_req_t;
endpackage

// File: verification/nvm_arr_model.sv
// Behavioural data EEPROM array behind the controller
`timescale 1ns/100ps
module nvm_arr_model (
  input  wire logic       clk_i,    // System clock
  input  wire logic [6:0] addr_i,   // Array address
  input  wire logic [7:0] wdata_i,  // Program data
  input  wire logic       rd_i,     // Read strobe
  input  wire logic       erase_i,  // Erase strobe
  input  wire logic       write_i,  // Program strobe
  output logic [7:0]      rdata_o   // Read data
);
  logic [7:0] mem [128];
  int         n_rd = 0;
  int         n_er = 0;
  logic [7:0] rdata_r = 8'h00;
  assign rdata_o = rdata_r;
  // Data valid one cycle after the strobe; toggles otherwise so stale data never matches
  always @(posedge clk_i) begin
    if (rd_i) begin
      rdata_r <= mem[addr_i];
      n_rd <= n_rd + 1;
    end else begin
      rdata_r <= ~rdata_r;
    end
    // Erased content reads zero
    if (erase_i) begin
      mem[addr_i] <= 8'h00;
      n_er <= n_er + 1;
    end
    if (write_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/100ps
`include "nvm_defines.svh"
module testbench;
  import nvm_pkg::*;
  localparam int ER0 = 20;  // Short program times
  localparam int WR0 = 30;
  localparam int ER1 = 50;
  localparam int WR1 = 70;
  logic         clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  nvm_mem_req_t mem_req_i = '0;
  logic [7:0]   mem_rdata_o;
  logic [6:0]   arr_addr_o;
  logic [7:0]   arr_wdata_o;
  logic [7:0]   arr_rdata_i;
  logic         arr_rd_o;
  logic         arr_erase_o;
  logic         arr_write_o;
  logic         busy_o;
  int           err_total = 0;
  int           checks_done = 0;
  int           busy_cyc = 0;
  int           exp_mem [128];
  int           a;
  int           n0;
  logic [7:0]   rv;
  logic [7:0]   v;
  logic [7:0]   starts [3] = '{8'h01, 8'h04, 8'h20};

  always #5 clk_i = ~clk_i;
  // Busy length in cycles, cleared before each program operation
  always @(posedge clk_i) if (busy_o === 1'b1) busy_cyc <= busy_cyc + 1;

  nvm_ctrl #(.ER0_CYC(ER0), .WR0_CYC(WR0), .ER1_CYC(ER1), .WR1_CYC(WR1)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_i), .mem_rdata_o(mem_rdata_o),
    .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o), .arr_rd_o(arr_rd_o), .arr_erase_o(arr_erase_o),
    .arr_write_o(arr_write_o), .arr_rdata_i(arr_rdata_i), .busy_o(busy_o));
  nvm_arr_model u_arr (.clk_i(clk_i), .addr_i(arr_addr_o), .wdata_i(arr_wdata_o), .rd_i(arr_rd_o),
    .erase_i(arr_erase_o), .write_i(arr_write_o), .rdata_o(arr_rdata_i));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Strobe held through one edge; a following read lowers it
  task automatic reg_wr(input logic [8:0] ad, input logic [7:0] d);
    mem_req_i = '{ad, 1'b1, d};
    @(posedge clk_i);
    #1;
  endtask
  task automatic reg_rd(input logic [8:0] ad, output logic [7:0] d);
    mem_req_i = '{ad, 1'b0, 8'h00};
    @(posedge clk_i);
    #1;
    d = mem_rdata_o;
  endtask
  // Wait for a self-clearing control bit, bounded
  task automatic poll(input int b);
    logic [7:0] c;
    for (int k = 0; k < 2000; k++) begin
      reg_rd(`NVM_CTRL_OFS, c);
      if (c[b] === 1'b0) return;
    end
    err_total++;
    final_report();
  endtask
  task automatic byte_rd(input int ad, output logic [7:0] d);
    reg_wr(`NVM_ADDR_OFS, 8'(ad));
    reg_wr(`NVM_CTRL_OFS, 8'h02);
    reg_wr(`NVM_CTRL_OFS, 8'h03);
    poll(`NVM_B_RD_GO);
    reg_rd(`NVM_DATA_OFS, d);
  endtask

  initial begin
    void'($urandom(32'h5a57));
    for (int i = 0; i < 128; i++) begin
      rv = 8'($urandom);
      u_arr.mem[i] = rv;
      exp_mem[i] = rv;
    end
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    // Reset values, and sector zero offset 40H is not the control register
    reg_rd(`NVM_ADDR_OFS, rv); check(rv, 8'h00);
    reg_rd(`NVM_DATA_OFS, rv); check(rv, 8'h00);
    reg_wr(9'h040, 8'h12);
    reg_rd(`NVM_CTRL_OFS, rv); check(rv, 8'h00);
    reg_wr(`NVM_ADDR_OFS, 8'hff);
    reg_rd(`NVM_ADDR_OFS, rv); check(rv, 8'h7f);
    // Start bits without their enables are dropped and touch no array
    foreach (starts[i]) begin
      reg_wr(`NVM_CTRL_OFS, starts[i]);
      reg_rd(`NVM_CTRL_OFS, rv); check(rv, 8'h00);
    end
    check(8'(u_arr.n_rd + u_arr.n_er), 8'h00);
    // Byte read holds the data and the address
    a = $urandom_range(127);
    byte_rd(a, rv); check(rv, 8'(exp_mem[a]));
    reg_rd(`NVM_ADDR_OFS, rv); check(rv, 8'(a));
    reg_rd(`NVM_DATA_OFS, rv); check(rv, 8'(exp_mem[a]));
    // Page read near the page end: offset saturates at 0FH
    a = ($urandom_range(7) << 4) | 4'hd;
    reg_wr(`NVM_ADDR_OFS, 8'(a));
    reg_wr(`NVM_CTRL_OFS, 8'h12);
    for (int j = 0; j < 4; j++) begin
      reg_wr(`NVM_CTRL_OFS, 8'h13);
      poll(`NVM_B_RD_GO);
      reg_rd(`NVM_DATA_OFS, rv); check(rv, 8'(exp_mem[(a & 8'h70) | ((a & 15) + j > 15 ? 15 : (a & 15) + j)]));
      reg_rd(`NVM_ADDR_OFS, rv); check(rv, 8'((a & 8'h70) | ((a & 15) + j + 1 > 15 ? 15 : (a & 15) + j + 1)));
    end
    // Byte write with short times: erase first, then program, enable self-clears
    a = $urandom_range(127);
    v = 8'($urandom);
    reg_wr(`NVM_ADDR_OFS, 8'(a));
    reg_wr(`NVM_DATA_OFS, v);
    reg_wr(`NVM_CTRL_OFS, 8'h08);
    n0 = u_arr.n_er;
    busy_cyc = 0;
    reg_wr(`NVM_CTRL_OFS, 8'h0c);
    poll(`NVM_B_WR_GO);
    reg_rd(`NVM_CTRL_OFS, rv); check(rv, 8'h00);
    check(8'(u_arr.n_er - n0), 8'h01);
    check(8'(busy_cyc >= ER0 + WR0 && busy_cyc <= ER0 + WR0 + 12), 8'h01);
    check(8'(busy_o), 8'h00);
    exp_mem[a] = v;
    byte_rd(a, rv); check(rv, 8'(exp_mem[a]));
    // Page write programs straight away, with no erase in front
    a = $urandom_range(127);
    v = 8'($urandom);
    reg_wr(`NVM_ADDR_OFS, 8'(a));
    reg_wr(`NVM_DATA_OFS, v);
    reg_wr(`NVM_CTRL_OFS, 8'h18);
    n0 = u_arr.n_er;
    busy_cyc = 0;
    reg_wr(`NVM_CTRL_OFS, 8'h1c);
    poll(`NVM_B_WR_GO);
    reg_rd(`NVM_CTRL_OFS, rv); check(rv, 8'h10);
    check(8'(u_arr.n_er - n0), 8'h00);
    check(8'(busy_cyc >= WR0 && busy_cyc <= WR0 + 12), 8'h01);
    check(8'(busy_o), 8'h00);
    exp_mem[a] = v;
    byte_rd(a, rv); check(rv, 8'(exp_mem[a]));
    // Byte erase with long times selected
    reg_wr(`NVM_CTRL_OFS, 8'h80);
    reg_wr(`NVM_CTRL_OFS, 8'hc0);
    busy_cyc = 0;
    reg_wr(`NVM_CTRL_OFS, 8'he0);
    poll(`NVM_B_ER_GO);
    reg_rd(`NVM_CTRL_OFS, rv); check(rv, 8'h80);
    check(8'(busy_cyc >= ER1 && busy_cyc <= ER1 + 12), 8'h01);
    check(8'(busy_o), 8'h00);
    exp_mem[a] = 0;
    byte_rd(a, rv); check(rv, 8'(exp_mem[a]));
    final_report();
  end
endmodule
